// >>> ahp_pkg.sv
// Package for the ATA host port pin control: shared constants and types.
// Assumes both ends run on one 125 MHz clock with active-low async reset.
package ahp_pkg;
  localparam int DATA_W = 16;
  localparam logic [1:0] MODE_PIO = 2'h0;
  localparam logic [1:0] MODE_MDMA = 2'h1;
  localparam logic [1:0] MODE_UDMA_IN = 2'h2;
  localparam logic [1:0] MODE_UDMA_OUT = 2'h3;
  localparam logic ROLE_MASTER = 1'h0;
  localparam logic ROLE_SLAVE = 1'h1;
  localparam logic [2:0] SYNC_INIT_HI = 3'h7;
  localparam int STRAP_WAIT_CYC = 4;
  localparam logic [2:0] STRAP_WAIT = 3'h4;
  typedef enum logic [1:0]
  {
    AHP_IDLE = 2'b00,
    AHP_REQ = 2'b01,
    AHP_XFER = 2'b10
  } ahp_dev_state_t;
endpackage

// >>> ahp_if.sv
// Interface joining the host and device ends of the ATA pin control.
// Assumes each end reads the other's data output directly; no shared data bus is resolved.
`timescale 1ns/10ps
interface ahp_if;
  logic dma_req;
  logic dma_ack_n;
  logic alt_register_select_n;
  logic command_block_select_n;
  logic read_strobe_n;
  logic write_strobe_n;
  logic strap_n;
  logic [15:0] dev_data_o;
  logic dev_data_oe;
  logic [15:0] host_data_o;
  logic host_data_oe;
  modport device
  (
    output dma_req,
    input dma_ack_n,
    input alt_register_select_n,
    input command_block_select_n,
    input read_strobe_n,
    input write_strobe_n,
    input strap_n,
    output dev_data_o,
    output dev_data_oe,
    input host_data_o,
    input host_data_oe
  );
  modport host
  (
    input dma_req,
    output dma_ack_n,
    output alt_register_select_n,
    output command_block_select_n,
    output read_strobe_n,
    output write_strobe_n,
    output strap_n,
    input dev_data_o,
    input dev_data_oe,
    output host_data_o,
    output host_data_oe
  );
endinterface

// >>> ahp_host.sv
// Host end: drives strobes, selects, DMA acknowledge and the strap.
// Assumes the device end shares clk and nrst.
`timescale 1ns/10ps
module ahp_host
(
  input wire logic clk,
  input wire logic nrst,
  ahp_if.host bus,
  input wire logic strap_master,
  input wire logic [1:0] mode,
  input wire logic rd_req,
  input wire logic alt_sel,
  input wire logic ack_allow,
  input wire logic ready_in,
  input wire logic wr_req,
  input wire logic [15:0] wr_data,
  output logic [15:0] rd_data,
  output logic rd_valid
);
  logic ack_n_ff, nxt_ack_n;
  logic rd_n_ff, nxt_rd_n;
  logic alt_n_ff, nxt_alt_n;
  logic wr_n_ff, nxt_wr_n;
  logic [15:0] wdata_ff, nxt_wdata;
  logic [15:0] rd_data_ff, nxt_rd_data;
  logic rd_valid_ff, nxt_rd_valid;
  logic udma;

  always_comb
  begin
    udma = (mode == ahp_pkg::MODE_UDMA_IN);
    // Acknowledge only a request the device raised
    nxt_ack_n = !(bus.dma_req && ack_allow);
    // Host-ready in UDMA-in, plain read strobe otherwise
    nxt_rd_n = udma ? !ready_in : !rd_req;
    nxt_alt_n = !((rd_req || wr_req) && alt_sel);
    nxt_wr_n = !wr_req;
    // Data held past the strobe: the device sees its edge late
    nxt_wdata = wr_req ? wr_data : wdata_ff;
    nxt_rd_valid = bus.dev_data_oe;
    nxt_rd_data = bus.dev_data_oe ? bus.dev_data_o : rd_data_ff;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ack_n_ff <= 1'h1;
      rd_n_ff <= 1'h1;
      alt_n_ff <= 1'h1;
      wr_n_ff <= 1'h1;
      wdata_ff <= 16'h0000;
      rd_data_ff <= 16'h0000;
      rd_valid_ff <= 1'h0;
    end
    else
    begin
      ack_n_ff <= nxt_ack_n;
      rd_n_ff <= nxt_rd_n;
      alt_n_ff <= nxt_alt_n;
      wr_n_ff <= nxt_wr_n;
      wdata_ff <= nxt_wdata;
      rd_data_ff <= nxt_rd_data;
      rd_valid_ff <= nxt_rd_valid;
    end
  end

  assign bus.dma_ack_n = ack_n_ff;
  assign bus.read_strobe_n = rd_n_ff;
  assign bus.alt_register_select_n = alt_n_ff;
  assign bus.command_block_select_n = 1'h1;
  assign bus.write_strobe_n = wr_n_ff;
  // Strap driven straight from the board input, not latched: strap_n follows strap_master at all times
  assign bus.strap_n = !strap_master;
  assign bus.host_data_o = wdata_ff;
  assign bus.host_data_oe = !wr_n_ff;
  assign rd_data = rd_data_ff;
  assign rd_valid = rd_valid_ff;
endmodule // ahp_host

// >>> ahp_device.sv
// Device end: DMA request, alternate register routing, strap role,
// and mode-dependent read strobe / host-ready handling.
// Assumes host pins are asynchronous; strobes, alternate select, acknowledge and strap are resynchronised here, write data is not.
`timescale 1ns/10ps
// Function
// - Host acknowledges a requested DMA transfer
// - Device requests DMA when data ready
// - Alternate select routes status/control registers
// - Pulled-up strap: low master, open slave
// - Strap level fixed across power cycle
// - Read data driven only during strobe
// - Read pin meaning follows transfer mode
// - Host-ready asserted during UDMA read
// - Negated host-ready pauses data sending
module ahp_device
(
  input wire logic clk,
  input wire logic nrst,
  ahp_if.device bus,
  input wire logic [1:0] mode,
  input wire logic data_ready,
  input wire logic [15:0] fifo_data,
  input wire logic [15:0] task_data,
  input wire logic [15:0] alt_status,
  output logic fifo_pop,
  output logic [7:0] dev_ctrl,
  output logic is_slave,
  output logic role_valid
);
  logic [2:0] ack_sync_ff, nxt_ack_sync;
  logic [2:0] rd_sync_ff, nxt_rd_sync;
  logic [2:0] alt_sync_ff, nxt_alt_sync;
  logic [2:0] wr_sync_ff, nxt_wr_sync;
  logic [2:0] strap_sync_ff, nxt_strap_sync;
  logic ack_ff, nxt_ack;
  logic rd_ff, nxt_rd;
  logic alt_ff, nxt_alt;
  logic wr_ff, nxt_wr;
  logic dma_req_ff, nxt_dma_req;
  logic [15:0] dout_ff, nxt_dout;
  logic oe_ff, nxt_oe;
  logic pop_ff, nxt_pop;
  logic [7:0] ctrl_ff, nxt_ctrl;
  logic slave_ff, nxt_slave;
  logic role_ok_ff, nxt_role_ok;
  logic [2:0] wait_ff, nxt_wait;
  ahp_pkg::ahp_dev_state_t state_ff, nxt_state;
  logic udma_in, rd_fall, wr_rise;

  // Settled level once stages two and three agree
  function automatic logic settle(input logic [2:0] s, input logic prev);
    settle = (s[1] == s[2]) ? s[2] : prev;
  endfunction

  always_comb
  begin
    nxt_ack_sync = {ack_sync_ff[1:0], bus.dma_ack_n};
    nxt_rd_sync = {rd_sync_ff[1:0], bus.read_strobe_n};
    nxt_alt_sync = {alt_sync_ff[1:0], bus.alt_register_select_n};
    nxt_wr_sync = {wr_sync_ff[1:0], bus.write_strobe_n};
    nxt_strap_sync = {strap_sync_ff[1:0], bus.strap_n};
    nxt_ack = !settle(ack_sync_ff, !ack_ff);
    nxt_rd = !settle(rd_sync_ff, !rd_ff);
    nxt_alt = !settle(alt_sync_ff, !alt_ff);
    nxt_wr = !settle(wr_sync_ff, !wr_ff);
  end

  always_comb
  begin
    udma_in = (mode == ahp_pkg::MODE_UDMA_IN);
    // First cycle of a seen strobe: one pop per strobe
    rd_fall = rd_ff && !oe_ff;
    wr_rise = !nxt_wr && wr_ff;
    nxt_state = state_ff;
    nxt_dma_req = dma_req_ff;
    nxt_pop = 1'h0;
    nxt_dout = dout_ff;
    nxt_oe = 1'h0;
    nxt_ctrl = ctrl_ff;
    nxt_wait = wait_ff;
    nxt_slave = slave_ff;
    nxt_role_ok = role_ok_ff;
    // Sample the strap once; later strap moves are ignored
    if (!role_ok_ff)
    begin
      if (wait_ff == ahp_pkg::STRAP_WAIT)
      begin
        // Open pin reads high through the pull-up: slave
        nxt_slave = settle(strap_sync_ff, slave_ff) ? ahp_pkg::ROLE_SLAVE
                                                    : ahp_pkg::ROLE_MASTER;
        nxt_role_ok = 1'h1;
      end
      else
        nxt_wait = wait_ff + 3'h1;
    end
    // Alternate select: reads alt status, writes device control
    if (alt_ff && wr_rise)
      nxt_ctrl = bus.host_data_o[7:0];
    case (state_ff)
      ahp_pkg::AHP_IDLE:
      begin
        if (data_ready && mode != ahp_pkg::MODE_PIO)
        begin
          nxt_dma_req = 1'h1;
          nxt_state = ahp_pkg::AHP_REQ;
        end
      end
      ahp_pkg::AHP_REQ:
      begin
        if (!data_ready)
        begin
          nxt_dma_req = 1'h0;
          nxt_state = ahp_pkg::AHP_IDLE;
        end
        else if (ack_ff)
          nxt_state = ahp_pkg::AHP_XFER;
      end
      ahp_pkg::AHP_XFER:
      begin
        if (!ack_ff || !data_ready)
        begin
          nxt_dma_req = 1'h0;
          nxt_state = ahp_pkg::AHP_IDLE;
        end
        else if (udma_in && rd_ff)
        begin
          // Host-ready negated is a pause: data flows only while ready
          nxt_oe = 1'h1;
          nxt_dout = fifo_data;
          nxt_pop = 1'h1;
        end
      end
      default:
      begin
        nxt_state = ahp_pkg::AHP_IDLE;
        nxt_dma_req = 1'h0;
      end
    endcase
    // Outside UDMA-in (PIO, MDMA and UDMA-out) the pin is a read strobe gating data out
    if (!udma_in && rd_ff)
    begin
      nxt_oe = 1'h1;
      if (alt_ff)
        nxt_dout = alt_status;
      else if (state_ff == ahp_pkg::AHP_XFER && ack_ff)
      begin
        nxt_dout = fifo_data;
        nxt_pop = rd_fall;
      end
      else
        nxt_dout = task_data;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ack_sync_ff <= ahp_pkg::SYNC_INIT_HI;
      rd_sync_ff <= ahp_pkg::SYNC_INIT_HI;
      alt_sync_ff <= ahp_pkg::SYNC_INIT_HI;
      wr_sync_ff <= ahp_pkg::SYNC_INIT_HI;
      strap_sync_ff <= ahp_pkg::SYNC_INIT_HI;
      ack_ff <= 1'h0;
      rd_ff <= 1'h0;
      alt_ff <= 1'h0;
      wr_ff <= 1'h0;
    end
    else
    begin
      ack_sync_ff <= nxt_ack_sync;
      rd_sync_ff <= nxt_rd_sync;
      alt_sync_ff <= nxt_alt_sync;
      wr_sync_ff <= nxt_wr_sync;
      strap_sync_ff <= nxt_strap_sync;
      ack_ff <= nxt_ack;
      rd_ff <= nxt_rd;
      alt_ff <= nxt_alt;
      wr_ff <= nxt_wr;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_ff <= ahp_pkg::AHP_IDLE;
      dma_req_ff <= 1'h0;
      dout_ff <= 16'h0000;
      oe_ff <= 1'h0;
      pop_ff <= 1'h0;
      ctrl_ff <= 8'h00;
      slave_ff <= 1'h0;
      role_ok_ff <= 1'h0;
      wait_ff <= 3'h0;
    end
    else
    begin
      state_ff <= nxt_state;
      dma_req_ff <= nxt_dma_req;
      dout_ff <= nxt_dout;
      oe_ff <= nxt_oe;
      pop_ff <= nxt_pop;
      ctrl_ff <= nxt_ctrl;
      slave_ff <= nxt_slave;
      role_ok_ff <= nxt_role_ok;
      wait_ff <= nxt_wait;
    end
  end

  assign bus.dma_req = dma_req_ff;
  assign bus.dev_data_o = dout_ff;
  assign bus.dev_data_oe = oe_ff;
  assign fifo_pop = pop_ff;
  assign dev_ctrl = ctrl_ff;
  assign is_slave = slave_ff;
  assign role_valid = role_ok_ff;
endmodule // ahp_device

// >>> ahp_asserts.sv
// Checker on the signals joining the host and device ends.
// Assumes one clock domain; placed beside the interface.
`timescale 1ns/10ps
module ahp_asserts
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic dma_req,
  input wire logic dma_ack_n,
  input wire logic read_strobe_n,
  input wire logic strap_n,
  input wire logic dev_data_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // Strobe must pass the synchroniser first
  oe_sync_late_a:
    assert property (!dev_data_oe && $fell(read_strobe_n) |=> !dev_data_oe)
    else $error("data enable too soon after strobe");
  oe_has_cause_a:
    assert property ($rose(dev_data_oe) |-> !read_strobe_n &&
      !$past(read_strobe_n, 2) && !$past(read_strobe_n, 3))
    else $error("data enable without held strobe");
  oe_stops_a:
    assert property ($rose(read_strobe_n) |-> ##[1:8] !dev_data_oe)
    else $error("data still driven after strobe release");
  oe_idle_a:
    assert property (read_strobe_n [*8] |-> !dev_data_oe)
    else $error("data driven with strobe idle");
  // One-cycle pulse never agrees in both late stages
  glitch_ignored_a:
    assert property (!dev_data_oe && $fell(read_strobe_n) ##1 read_strobe_n
      |=> !dev_data_oe [*4])
    else $error("short strobe pulse accepted");
  ack_after_req_a:
    assert property ($fell(dma_ack_n) |-> $past(dma_req) || $past(dma_req, 2))
    else $error("acknowledge without request");
  req_before_ack_a:
    assert property ($rose(dma_req) |-> dma_ack_n)
    else $error("request raised under acknowledge");
  strap_fixed_a:
    assert property ($past(nrst, 2) |-> $stable(strap_n))
    else $error("strap moved while running");
endmodule // ahp_asserts

// >>> testbench.sv
// Testbench: host and device ends joined by the interface, with checker.
// Assumes 125 MHz clk; inputs change on the falling edge.
`timescale 1ns/10ps
module testbench;
  logic clk;
  logic nrst;
  logic strap_master;
  logic [1:0] mode;
  logic rd_req;
  logic alt_sel;
  logic ack_allow;
  logic ready_in;
  logic wr_req;
  logic [15:0] wr_data;
  logic data_ready;
  logic [15:0] fifo_data;
  logic [15:0] task_data;
  logic [15:0] alt_status;
  logic [15:0] rd_data;
  logic rd_valid;
  logic fifo_pop;
  logic [7:0] dev_ctrl;
  logic is_slave;
  logic role_valid;
  int fails;
  int num_checks;
  int n;
  int pops = 0;
  ahp_if ahp_if_i();
  ahp_host ahp_host_i
  (
    .clk(clk), .nrst(nrst), .bus(ahp_if_i.host),
    .strap_master(strap_master), .mode(mode), .rd_req(rd_req),
    .alt_sel(alt_sel), .ack_allow(ack_allow), .ready_in(ready_in),
    .wr_req(wr_req), .wr_data(wr_data),
    .rd_data(rd_data), .rd_valid(rd_valid)
  );
  ahp_device ahp_device_i
  (
    .clk(clk), .nrst(nrst), .bus(ahp_if_i.device), .mode(mode),
    .data_ready(data_ready), .fifo_data(fifo_data),
    .task_data(task_data), .alt_status(alt_status),
    .fifo_pop(fifo_pop), .dev_ctrl(dev_ctrl), .is_slave(is_slave),
    .role_valid(role_valid)
  );
  ahp_asserts ahp_asserts_i
  (
    .clk(clk), .nrst(nrst), .dma_req(ahp_if_i.dma_req),
    .dma_ack_n(ahp_if_i.dma_ack_n), .read_strobe_n(ahp_if_i.read_strobe_n),
    .strap_n(ahp_if_i.strap_n), .dev_data_oe(ahp_if_i.dev_data_oe)
  );
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk)
    if (fifo_pop === 1'b1)
      pops <= pops + 1;
  task automatic chk_data(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_data({15'h0, got}, {15'h0, exp});
  endtask
  // Bounded wait, so a stuck flag fails instead of hanging
  task automatic wait_for(ref logic s, input logic v);
    int k;
    k = 0;
    while (s !== v && k < 40)
    begin
      @(negedge clk);
      k++;
    end
    chk_bit(s, v);
  endtask
  task automatic count(ref logic s, input int cyc, output int c);
    c = 0;
    repeat (cyc)
    begin
      @(negedge clk);
      if (s !== 1'b0)
        c++;
    end
  endtask
  task automatic do_reset(input logic sm);
    nrst = 1'b0;
    strap_master = sm;
    repeat (20) @(negedge clk);
    nrst = 1'b1;
    wait_for(role_valid, 1'b1);
    chk_bit(is_slave, sm ? ahp_pkg::ROLE_MASTER : ahp_pkg::ROLE_SLAVE);
    chk_data({8'h0, dev_ctrl}, 16'h0);
  endtask
  task automatic rd(input logic [1:0] m, input logic alt,
    input logic [15:0] exp);
    int p;
    mode = m;
    alt_sel = alt;
    data_ready = (m != ahp_pkg::MODE_PIO);
    // DMA strobes only once the acknowledge has settled in the device
    if (m != ahp_pkg::MODE_PIO)
    begin
      repeat (8) @(negedge clk);
      chk_bit(ahp_if_i.dma_req, 1'b1);
      chk_bit(ahp_if_i.dma_ack_n, 1'b0);
    end
    p = pops;
    rd_req = 1'b1;
    ready_in = 1'b1;
    wait_for(rd_valid, 1'b1);
    chk_data(rd_data, exp);
    chk_data(16'(pops - p), (m == ahp_pkg::MODE_PIO) ? 16'h0 : 16'h1);
    rd_req = 1'b0;
    ready_in = 1'b0;
    data_ready = 1'b0;
    wait_for(rd_valid, 1'b0);
  endtask
  task automatic wr(input logic alt, input logic [15:0] d,
    input logic [7:0] exp);
    alt_sel = alt;
    wr_data = d;
    wr_req = 1'b1;
    repeat (6) @(negedge clk);
    wr_req = 1'b0;
    repeat (8) @(negedge clk);
    chk_data({8'h0, dev_ctrl}, {8'h0, exp});
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    fails = 0;
    num_checks = 0;
    mode = ahp_pkg::MODE_PIO;
    {rd_req, alt_sel, ready_in, data_ready} = 4'h0;
    wr_req = 1'b0;
    wr_data = 16'h0000;
    ack_allow = 1'b1;
    fifo_data = 16'hC35A;
    task_data = 16'h1234;
    alt_status = 16'hA5C3;
    do_reset(1'b1);
    rd(ahp_pkg::MODE_PIO, 1'b0, task_data);
    rd(ahp_pkg::MODE_PIO, 1'b1, alt_status);
    rd(ahp_pkg::MODE_MDMA, 1'b0, fifo_data);
    $display("reads done");
    wr(1'b1, 16'h005A, 8'h5A);
    wr(1'b0, 16'h00C3, 8'h5A);
    $display("writes done");
    rd_req = 1'b1;
    @(negedge clk);
    rd_req = 1'b0;
    count(rd_valid, 12, n);
    chk_data(n[15:0], 16'h0);
    $display("glitch done");
    mode = ahp_pkg::MODE_UDMA_IN;
    data_ready = 1'b1;
    repeat (2) @(negedge clk);
    chk_bit(ahp_if_i.dma_req, 1'b1);
    ready_in = 1'b1;
    wait_for(rd_valid, 1'b1);
    count(fifo_pop, 8, n);
    chk_data(n[15:0], 16'h8);
    ready_in = 1'b0;
    repeat (10) @(negedge clk);
    count(fifo_pop, 8, n);
    chk_data(n[15:0], 16'h0);
    chk_bit(ahp_if_i.dev_data_oe, 1'b0);
    ready_in = 1'b1;
    wait_for(rd_valid, 1'b1);
    chk_data(rd_data, fifo_data);
    {ready_in, data_ready} = 2'h0;
    $display("ultra dma done");
    do_reset(1'b0);
    $display("role done");
    print_verdict;
  end
  initial
  begin
    #40000;
    fails++;
    print_verdict;
  end
endmodule // testbench
